//--- hw/fcc_ctrl.sv
// flash charger control: charge sequencing, limit decoding, mode and done
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - charging starts only on charge rising edge while supply is above lockout
// - charge already high at supply rise needs a fresh rising edge
// - charge low then high restarts charging from the beginning, except inside the setup burst window
// - switching stops when the sensed output trips its target
// - output is sensed in the off interval, only after 200 ns
// - after turn-off in fast mode, switch is turned back on at the slope minimum
// - timer mode is used while the output is low
// - timer mode off-time is a fixed 13 us
// - fast mode above about 50 V uses zero-voltage switching
// - eight limit levels, 100% down to 50%, 7% steps except an 8% step from 79% to 71%
// - decoder completes and applies the setting after 45 us setup
// - switching starts only after the setup period ends
// - limit level is held while charge stays high
// - charge low resets the decoder before a new setting
// - first rising edge starts the decoder, up to 7 further edges counted
// - limit encoding: no extra pulse 100%, one 93%, seven 50%
// - done open-drain pulls low at target with charge high, else released
// - gate drive follows the trigger input high
module fcc_ctrl (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // host pins
  input wire logic charge_en,
  input wire logic flash_trigger,
  // analog front end
  input wire fcc_pkg::fcc_sense_s sense,
  // outputs
  output fcc_pkg::fcc_drive_s drive,
  output logic done_n_out,
  output logic done_n_oe,
  output logic gate_drive_source,
  output logic standby
);
  import fcc_pkg::*;

  function automatic logic [6:0] pct_of(input logic [2:0] code);
    pct_of = 7'(PCT_100 - 7'(code) * PCT_STEP - ((code >= 3'h4) ? 7'h1 : 7'h0));
  endfunction

  logic chg_s, trig_s, chg_d_reg;
  fcc_sync u_sync_chg (.mclk(mclk), .rst(rst), .din(charge_en), .dout(chg_s));
  fcc_sync u_sync_trig (.mclk(mclk), .rst(rst), .din(flash_trigger), .dout(trig_s));

  wire chg_rise = chg_s & ~chg_d_reg;
  wire start_ok = chg_rise & sense.supply_ok;

  fcc_state_e state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [2:0] edges_reg, edges_next;
  logic fast_reg, fast_next;
  logic [2:0] limit_reg, limit_next;

  wire setup_end = (state_reg == FCC_SETUP) && (cnt_reg == CNT_W'(SETUP_CYC - 1));
  wire in_burst = (state_reg == FCC_SETUP) && (cnt_reg < CNT_W'(BURST_CYC));
  wire sense_ok = (cnt_reg >= CNT_W'(SENSE_MIN_CYC));
  wire timer_end = (cnt_reg >= CNT_W'(TIMER_OFF_CYC - 1));
  wire reon = fast_reg ? sense.slope_min : timer_end;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg + CNT_W'(1);
    edges_next = edges_reg;
    fast_next = fast_reg;
    limit_next = limit_reg;
    case (state_reg)
      FCC_IDLE: begin
        cnt_next = '0;
        if (start_ok) begin
          state_next = FCC_SETUP;
          edges_next = 3'h0;
          fast_next = 1'b0;
        end
      end
      FCC_SETUP: begin
        if (chg_rise && in_burst && edges_reg != LIMIT_MAX)
          edges_next = edges_reg + 3'h1;
        if (setup_end) begin
          limit_next = edges_next;
          state_next = FCC_ON;
          cnt_next = '0;
        end
      end
      FCC_ON: begin
        if (sense.peak_reached) begin
          state_next = FCC_OFF;
          cnt_next = '0;
        end
      end
      FCC_OFF: begin
        if (sense_ok && sense.out_trip) begin
          state_next = FCC_DONE;
        end else if (sense_ok && reon) begin
          state_next = FCC_ON;
          cnt_next = '0;
        end
        // mode only updated from a valid measurement
        if (sense_ok && sense.out_high)
          fast_next = 1'b1;
        else if (sense_ok && sense.out_low)
          fast_next = 1'b0;
      end
      FCC_DONE: cnt_next = cnt_reg;
      default: state_next = FCC_IDLE;
    endcase
    // lows inside the burst window are programming gaps, not a restart;
    // a host that gives up mid-burst is idled once the window closes
    if (!chg_s && !in_burst) begin
      state_next = FCC_IDLE;
      fast_next = 1'b0;
      limit_next = LIMIT_RST;
      edges_next = 3'h0;
    end
    if (state_next == FCC_IDLE)
      cnt_next = '0;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg <= FCC_IDLE;
      cnt_reg <= '0;
      edges_reg <= 3'h0;
      fast_reg <= 1'b0;
      limit_reg <= LIMIT_RST;
      chg_d_reg <= 1'b1; // no edge can be flagged while the synchroniser still shows its reset low
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      edges_reg <= edges_next;
      fast_reg <= fast_next;
      limit_reg <= limit_next;
      chg_d_reg <= chg_s;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      drive <= '0;
      done_n_oe <= 1'b0;
      done_n_out <= 1'b0;
      gate_drive_source <= 1'b0;
      standby <= 1'b1;
    end else begin
      drive.switch_on <= (state_next == FCC_ON);
      drive.fast_mode <= fast_next;
      drive.limit_code <= limit_next;
      drive.limit_pct <= pct_of(limit_next);
      done_n_oe <= (state_next == FCC_DONE) && chg_s;
      done_n_out <= 1'b0;
      gate_drive_source <= trig_s;
      standby <= (state_next == FCC_IDLE);
    end
  end

  property p_start;
    @(posedge mclk) disable iff (rst)
      (state_reg == FCC_IDLE && start_ok && chg_s) |=> state_reg == FCC_SETUP;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");

  property p_no_start;
    @(posedge mclk) disable iff (rst)
      (state_reg == FCC_IDLE && !start_ok) |=> state_reg == FCC_IDLE;
  endproperty
  a_no_start: assert property (p_no_start) else $error("started without edge or supply");

  property p_drop;
    @(posedge mclk) disable iff (rst)
      (!chg_s && !in_burst) |=> (state_reg == FCC_IDLE && limit_reg == LIMIT_RST && !fast_reg);
  endproperty
  a_drop: assert property (p_drop) else $error("charge low did not idle");

  property p_setup_len;
    @(posedge mclk) disable iff (rst)
      $rose(state_reg == FCC_SETUP) |-> (state_reg == FCC_SETUP || !chg_s) [*8];
  endproperty
  a_setup_len: assert property (p_setup_len) else $error("setup left early");

  property p_setup_end;
    @(posedge mclk) disable iff (rst) (setup_end && chg_s) |=> (state_reg == FCC_ON && limit_reg == $past(edges_next));
  endproperty
  a_setup_end: assert property (p_setup_end) else $error("limit not applied");

  property p_hold;
    @(posedge mclk) disable iff (rst) (state_reg != FCC_SETUP && chg_s) |=> $stable(limit_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("limit changed while charging");

  property p_sense;
    @(posedge mclk) disable iff (rst)
      (state_reg == FCC_OFF && cnt_reg < CNT_W'(SENSE_MIN_CYC)) |=> state_reg != FCC_DONE;
  endproperty
  a_sense: assert property (p_sense) else $error("trip taken before sense window");

  property p_timer;
    @(posedge mclk) disable iff (rst)
      (state_reg == FCC_OFF && !fast_reg && cnt_reg < CNT_W'(TIMER_OFF_CYC - 1)) |=> state_reg != FCC_ON;
  endproperty
  a_timer: assert property (p_timer) else $error("timer off-time too short");

  property p_done;
    @(posedge mclk) disable iff (rst) (state_reg == FCC_DONE && chg_s) |-> ##1 done_n_oe;
  endproperty
  a_done: assert property (p_done) else $error("done not pulled low");

  property p_trig;
    @(posedge mclk) disable iff (rst) trig_s |=> gate_drive_source;
  endproperty
  a_trig: assert property (p_trig) else $error("gate drive not following trigger");

  c_setup: cover property (@(posedge mclk) disable iff (rst) setup_end);
  c_fast: cover property (@(posedge mclk) disable iff (rst) $rose(fast_reg));
  c_done: cover property (@(posedge mclk) disable iff (rst) $rose(done_n_oe));
  c_lim7: cover property (@(posedge mclk) disable iff (rst) limit_reg == LIMIT_MAX);
endmodule
`default_nettype wire

//--- shared/fcc_pkg.sv
// shared constants and types for the flash charger control block
package fcc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 100;
  // time figures in their own units
  localparam int unsigned T_TIMER_OFF_US = 13;
  localparam int unsigned T_SENSE_MIN_NS = 200;
  localparam int unsigned T_SETUP_US = 45;
  localparam int unsigned T_BURST_MAX_US = 40;
  // derived cycle counts (least times rounded up)
  localparam int unsigned TIMER_OFF_CYC = (T_TIMER_OFF_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SENSE_MIN_CYC = (T_SENSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETUP_CYC = (T_SETUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BURST_CYC = (T_BURST_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 10;
  // limit code: 0 = 100%, 7 = 50%
  localparam logic [2:0] LIMIT_RST = 3'h0;
  localparam logic [2:0] LIMIT_MAX = 3'h7;
  // percentage table per code, 7% steps except 8% from code 3 to code 4
  localparam logic [6:0] PCT_100 = 7'h64;
  localparam logic [6:0] PCT_STEP = 7'h07;

  typedef enum logic [2:0] {
    FCC_IDLE = 3'b000,
    FCC_SETUP = 3'b001,
    FCC_ON = 3'b011,
    FCC_OFF = 3'b010,
    FCC_DONE = 3'b110
  } fcc_state_e;

  // analog front-end status seen by the sequencer
  typedef struct packed {
    logic supply_ok;
    logic peak_reached;
    logic out_trip;
    logic out_low;
    logic out_high;
    logic slope_min;
  } fcc_sense_s;

  // switch drive and status
  typedef struct packed {
    logic switch_on;
    logic fast_mode;
    logic [2:0] limit_code;
    logic [6:0] limit_pct;
  } fcc_drive_s;
endpackage

//--- hw/fcc_sync.sv
// two-stage synchroniser for one input level
`timescale 1ns/100ps
`default_nettype none
module fcc_sync (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // level
  input wire logic din,
  output logic dout
);
  logic meta_reg;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta_reg <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end
endmodule
`default_nettype wire

//--- tb/fcc_host_model.sv
// host controller model driving the charge and trigger lines
`timescale 1ns/100ps
`default_nettype none
module fcc_host_model (
  // clock
  input wire logic mclk,
  // host pins
  output logic charge_en,
  output logic flash_trigger
);
  initial begin
    charge_en = 1'b0;
    flash_trigger = 1'b0;
  end
  // line goes low first so the decoder restarts; it is left high after the burst
  task automatic burst(input int extra);
    @(negedge mclk) charge_en = 1'b0;
    repeat (6) @(negedge mclk);
    charge_en = 1'b1;
    repeat (160) @(negedge mclk);
    for (int i = 0; i < extra; i++) begin
      charge_en = 1'b0;
      repeat (2) @(negedge mclk);
      charge_en = 1'b1;
      repeat (2) @(negedge mclk);
    end
  endtask
  task automatic drop();
    @(negedge mclk) charge_en = 1'b0;
  endtask
  task automatic trig(input logic v);
    @(negedge mclk) flash_trigger = v;
  endtask
endmodule
`default_nettype wire

//--- tb/flash_charger_control_bench.sv
// self-checking bench for the flash charger control block
`timescale 1ns/100ps
`default_nettype none
module flash_charger_control_bench;
  import fcc_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic charge_en, flash_trigger, done_n_out, done_n_oe, gate_drive_source, standby;
  fcc_sense_s sense = '0;
  fcc_drive_s drive;
  int err_count = 0;
  int num_checks = 0;
  logic [6:0] pct_tab [8] = '{7'h64, 7'h5d, 7'h56, 7'h4f, 7'h47, 7'h40, 7'h39, 7'h32};

  always #50 mclk = ~mclk;

  fcc_host_model host (.mclk(mclk), .charge_en(charge_en), .flash_trigger(flash_trigger));
  fcc_ctrl uut (.mclk(mclk), .rst(rst), .charge_en(charge_en), .flash_trigger(flash_trigger),
    .sense(sense), .drive(drive), .done_n_out(done_n_out), .done_n_oe(done_n_oe),
    .gate_drive_source(gate_drive_source), .standby(standby));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %h %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    if (err_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // a missing switch turn-on would otherwise hang the run
  task automatic wait_on(input int lim);
    int n;
    n = 0;
    while (drive.switch_on !== 1'b1 && n < lim) begin
      @(negedge mclk);
      n++;
    end
    if (drive.switch_on !== 1'b1) begin
      err_count++;
      report_and_stop();
    end
  endtask
  task automatic t_reset();
    chk(16'(standby), 16'h1);
    chk(16'(drive), 16'h0);
    chk(16'(done_n_oe), 16'h0);
  endtask
  task automatic t_lockout();
    host.burst(0);
    repeat (500) @(negedge mclk);
    chk(16'(standby), 16'h1);
    chk(16'(drive.switch_on), 16'h0);
    sense.supply_ok = 1'b1;
    repeat (20) @(negedge mclk);
    chk(16'(standby), 16'h1);
  endtask
  task automatic t_limit(input int n);
    host.burst(n);
    repeat (250) @(negedge mclk);
    chk(16'(drive.switch_on), 16'h0);
    chk(16'(standby), 16'h0);
    wait_on(100);
    chk(16'(drive.limit_code), 16'(n));
    chk(16'(drive.limit_pct), 16'(pct_tab[n]));
  endtask
  task automatic t_timer();
    sense.out_low = 1'b1;
    sense.peak_reached = 1'b1;
    repeat (3) @(negedge mclk);
    chk(16'(drive.switch_on), 16'h0);
    sense.peak_reached = 1'b0;
    repeat (125) @(negedge mclk);
    chk(16'(drive.switch_on), 16'h0);
    wait_on(4);
  endtask
  task automatic t_fast();
    sense.out_low = 1'b0;
    sense.out_high = 1'b1;
    sense.peak_reached = 1'b1;
    repeat (3) @(negedge mclk);
    sense.peak_reached = 1'b0;
    repeat (200) @(negedge mclk);
    chk(16'(drive.fast_mode), 16'h1);
    chk(16'(drive.switch_on), 16'h0);
    sense.slope_min = 1'b1;
    wait_on(4);
    sense.slope_min = 1'b0;
  endtask
  task automatic t_done();
    sense.peak_reached = 1'b1;
    sense.out_trip = 1'b1;
    repeat (10) @(negedge mclk);
    chk(16'(done_n_oe), 16'h1);
    chk(16'(done_n_out), 16'h0);
    chk(16'(drive.switch_on), 16'h0);
    chk(16'(drive.limit_code), 16'h7);
    host.drop();
    repeat (8) @(negedge mclk);
    chk(16'(done_n_oe), 16'h0);
    chk(16'(standby), 16'h1);
    chk(16'(drive.fast_mode), 16'h0);
    sense.peak_reached = 1'b0;
    sense.out_trip = 1'b0;
  endtask
  task automatic t_trigger();
    host.trig(1'b1);
    repeat (4) @(negedge mclk);
    chk(16'(gate_drive_source), 16'h1);
    host.trig(1'b0);
    repeat (4) @(negedge mclk);
    chk(16'(gate_drive_source), 16'h0);
  endtask

  initial begin
    repeat (12) @(negedge mclk);
    rst = 1'b0;
    t_reset();
    t_lockout();
    for (int n = 0; n < 8; n++) begin
      t_limit(n);
    end
    t_timer();
    t_fast();
    t_done();
    t_trigger();
    report_and_stop();
  end
endmodule
`default_nettype wire
